/* File: logic/eeprom_pkg.sv */
// Shared constants, states and carriers of the two-wire EEPROM slave engine.
package eeprom_pkg;

  // ==========================================================================
  // Array and page geometry (512 x 8 array, 16-byte pages, one address byte).
  localparam int          BYTE_W      = 8;
  localparam int          MEM_ADDR_W  = 9;
  localparam int          MEM_DEPTH   = 512;
  localparam int          PAGE_ADDR_W = 4;
  localparam int          PAGE_BYTES  = 16;
  localparam int          BIT_CNT_W   = 4;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [3:0]  BIT_ZERO    = 4'h0;
  localparam logic [3:0]  BIT_STEP    = 4'h1;
  localparam logic [3:0]  PAGE_STEP   = 4'h1;
  localparam logic [8:0]  ADDR_STEP   = 9'h001;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  // ==========================================================================
  // Slave address byte layout.
  localparam int          SA_TYPE_HI  = 7;
  localparam int          SA_TYPE_LO  = 4;
  localparam int          SA_SEL_HI   = 3;
  localparam int          SA_SEL_LO   = 2;
  localparam int          SA_PAGE     = 1;
  localparam int          SA_RW       = 0;
  localparam int          BYTE_MSB    = 7;
  localparam int          SHIFT_NEXT  = 6;
  // Device-type code; the value is arbitrary.
  localparam logic [3:0]  DEV_TYPE_DEFAULT = 4'h5;

  // ==========================================================================
  // Internal write time.
  localparam int          WRITE_TIME_MS   = 5;
  localparam int          NS_PER_MS       = 1000000;
  localparam int          CLOCK_PERIOD_NS = 100;
  localparam int          WRITE_CYCLES    = (WRITE_TIME_MS * NS_PER_MS) / CLOCK_PERIOD_NS;
  localparam int          TIMER_W         = 24;
  localparam logic [23:0] TIMER_ZERO      = 24'h000000;
  localparam logic [23:0] TIMER_STEP      = 24'h000001;

  // ==========================================================================
  // Protocol states.
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_SLAVE    = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_WADDR    = 4'h3,
    ST_ACK_WORD = 4'h4,
    ST_WDATA    = 4'h5,
    ST_ACK_DATA = 4'h6,
    ST_RDATA    = 4'h7,
    ST_RACK     = 4'h8,
    ST_WAITSTOP = 4'h9
  } state_e;

  // Pins that are sampled together into the link domain.
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [1:0] sel;
  } pins_s;

endpackage : eeprom_pkg

/* File: logic/eeprom_slave.sv */
// Two-wire serial EEPROM slave: protocol engine, array and write timer.
// ============================================================================
// How it works
// - Sender releases data after each byte; receiver pulls it low on ninth clock.
// - A start plus matching slave address is acknowledged low.
// - Every word address and data byte of a write is acknowledged low.
// - After a read byte, a low acknowledge without stop sends the next byte.
// - No acknowledge after a read byte: release data, wait for stop, go idle.
// - Top four address bits must equal the device-type code, else ignored.
// - Next address bits are compared with the device-select pins.
// - A page-select bit in a write-mode slave address forms the top memory address bit.
// - Address bit zero picks write (0) or read (1).
// - One word-address byte at this capacity; unused high bits are don't-care.
// - During an internal write every command is ignored and never acknowledged.
// - Data goes from the given address; writing starts at stop after a full byte.
// - Commands are refused for the internal write time, at most 5 ms.
// - A page write takes up to 16 consecutive bytes.
// - Only the in-page address bits increment per data byte.
// - Extra bytes wrap to the page start and overwrite earlier ones.
// - Any byte count from one up to the page size is accepted.
// - A full page takes no longer to write than a single byte.
// - Write-protect high inhibits all writes; low allows them.
// - A random read returns the loaded address, then follows sequentially.
// - A current read returns the byte at last accessed address plus one.
// - Transfers are bytes of eight bits, each followed by an acknowledge.
// - Both lines are watched for a start; nothing runs without one.
// - A command ends with a stop, data rising while clock is high.
`timescale 1ns/100ps
`default_nettype none

module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int         WRITE_CYCLES_P = WRITE_CYCLES,
  parameter logic [3:0] DEV_TYPE_P     = DEV_TYPE_DEFAULT
) (
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  input  wire logic link_clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic device_select_pin_2_in,
  input  wire logic device_select_pin_1_in,
  input  wire logic write_protect_in,
  output var  logic sda_drive_out,
  output var  logic sda_oe_b_out,
  output var  logic write_busy_out
);

  // ==========================================================================
  // Declarations.
  pins_s                  pins_raw;
  pins_s                  pins;
  logic                   scl_q_ff;
  logic                   sda_q_ff;
  state_e                 state_ff;
  state_e                 nxt_state;
  logic [BIT_CNT_W-1:0]   bit_cnt_ff;
  logic [BIT_CNT_W-1:0]   nxt_bit_cnt;
  logic [BYTE_W-1:0]      shift_ff;
  logic [BYTE_W-1:0]      nxt_shift;
  logic [MEM_ADDR_W-1:0]  addr_ff;
  logic [MEM_ADDR_W-1:0]  nxt_addr;
  logic                   page_bit_ff;
  logic                   nxt_page_bit;
  logic                   mack_ff;
  logic                   nxt_mack;
  logic                   have_data_ff;
  logic                   nxt_have_data;
  logic                   oe_b_ff;
  logic                   nxt_oe_b;
  logic                   req_ff;
  logic                   ack_ff;
  logic                   ack_s;
  logic                   req_s;
  logic                   busy_ff;
  logic [TIMER_W-1:0]     timer_ff;
  logic [TIMER_W-1:0]     busy_len_ff;
  logic [PAGE_BYTES-1:0]  pmask_ff;
  logic [BYTE_W-1:0]      pbuf [PAGE_BYTES];
  logic [BYTE_W-1:0]      mem  [MEM_DEPTH];

  // ==========================================================================
  // Pin synchronisation into the link domain.
  assign pins_raw = '{scl: scl_in, sda: sda_in, wp: write_protect_in,
                      sel: {device_select_pin_2_in, device_select_pin_1_in}};

  eeprom_sync #(.WIDTH($bits(pins_s))) u_pin_sync (
    .clk_in   (link_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (pins_raw),
    .q_out    (pins)
  );

  eeprom_sync #(.WIDTH(1)) u_ack_sync (
    .clk_in   (link_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (ack_ff),
    .q_out    (ack_s)
  );

  // ==========================================================================
  // Line events and decodes.
  function automatic logic slave_hit(input logic [7:0] sa, input logic [1:0] sel,
                                     input logic [3:0] code);
    slave_hit = (sa[SA_TYPE_HI:SA_TYPE_LO] == code) && (sa[SA_SEL_HI:SA_SEL_LO] == sel);
  endfunction

  // Start and stop are data edges while the clock stays high.
  wire scl_rise  = pins.scl & ~scl_q_ff;
  wire scl_fall  = ~pins.scl & scl_q_ff;
  wire start_ev  = pins.scl & scl_q_ff & sda_q_ff & ~pins.sda;
  wire stop_ev   = pins.scl & scl_q_ff & ~sda_q_ff & pins.sda;
  wire byte_full = (bit_cnt_ff == BYTE_BITS);
  wire byte_end  = scl_fall & byte_full;
  // A toggle request still unanswered by the timer domain means writing.
  wire wr_busy   = req_ff ^ ack_s;
  wire addr_hit  = slave_hit(shift_ff, pins.sel, DEV_TYPE_P);
  wire rd_req    = shift_ff[SA_RW];
  wire [BYTE_W-1:0] rd_byte = mem[addr_ff];
  wire buf_we    = (state_ff == ST_WDATA) & byte_end & ~stop_ev & ~start_ev;
  // A stop's own clock rise is counted as a bit, so zero or one counted bits mean a whole byte.
  wire data_whole = (state_ff == ST_ACK_DATA) | ((state_ff == ST_WDATA) & (bit_cnt_ff <= BIT_STEP));
  wire commit    = stop_ev & have_data_ff & data_whole & ~pins.wp;

  // ==========================================================================
  // Protocol state machine, next-state logic.
  always_comb begin
    nxt_state     = state_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_shift     = shift_ff;
    nxt_addr      = addr_ff;
    nxt_page_bit  = page_bit_ff;
    nxt_mack      = mack_ff;
    nxt_have_data = have_data_ff;
    nxt_oe_b      = oe_b_ff;
    if (stop_ev) begin
      nxt_state = ST_IDLE;
      nxt_oe_b  = 1'b1;
    end else if (start_ev) begin
      // While writing, a start is dropped and nothing answers.
      nxt_state     = wr_busy ? ST_IDLE : ST_SLAVE;
      nxt_bit_cnt   = BIT_ZERO;
      nxt_oe_b      = 1'b1;
      nxt_have_data = 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE, ST_WAITSTOP: begin
          nxt_oe_b = 1'b1;
        end
        ST_SLAVE, ST_WADDR, ST_WDATA: begin
          if (scl_rise && !byte_full) begin
            nxt_shift   = {shift_ff[SHIFT_NEXT:0], pins.sda};
            nxt_bit_cnt = bit_cnt_ff + BIT_STEP;
          end else if (byte_end) begin
            nxt_oe_b = 1'b0;
            if (state_ff == ST_SLAVE) begin
              nxt_state    = addr_hit ? ST_ACK_ADDR : ST_IDLE;
              nxt_oe_b     = ~addr_hit;
              nxt_page_bit = shift_ff[SA_PAGE];
            end else if (state_ff == ST_WADDR) begin
              nxt_addr  = {page_bit_ff, shift_ff};
              nxt_state = ST_ACK_WORD;
            end else begin
              // In-page index wraps; upper address bits never move here.
              nxt_addr[PAGE_ADDR_W-1:0] = addr_ff[PAGE_ADDR_W-1:0] + PAGE_STEP;
              nxt_have_data = 1'b1;
              nxt_state     = ST_ACK_DATA;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WORD, ST_ACK_DATA: begin
          if (scl_fall) begin
            nxt_bit_cnt = BIT_ZERO;
            nxt_oe_b    = 1'b1;
            nxt_state   = (state_ff == ST_ACK_ADDR) ? ST_WADDR : ST_WDATA;
            if (state_ff == ST_ACK_ADDR && rd_req) begin
              // Current read: no address phase, the held address is used.
              nxt_shift = rd_byte;
              nxt_oe_b  = rd_byte[BYTE_MSB];
              nxt_state = ST_RDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise && !byte_full) begin
            nxt_bit_cnt = bit_cnt_ff + BIT_STEP;
          end else if (byte_end) begin
            nxt_oe_b  = 1'b1;
            nxt_addr  = addr_ff + ADDR_STEP;
            nxt_state = ST_RACK;
          end else if (scl_fall) begin
            nxt_shift = {shift_ff[SHIFT_NEXT:0], 1'b0};
            nxt_oe_b  = shift_ff[SHIFT_NEXT];
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nxt_mack = ~pins.sda;
          end else if (scl_fall) begin
            nxt_bit_cnt = BIT_ZERO;
            nxt_shift   = rd_byte;
            nxt_oe_b    = mack_ff ? rd_byte[BYTE_MSB] : 1'b1;
            nxt_state   = mack_ff ? ST_RDATA : ST_WAITSTOP;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_oe_b  = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Link-domain registers.
  always_ff @(posedge link_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_q_ff      <= 1'b1;
      sda_q_ff      <= 1'b1;
      state_ff      <= ST_IDLE;
      bit_cnt_ff    <= BIT_ZERO;
      shift_ff      <= BYTE_ZERO;
      addr_ff       <= '0;
      page_bit_ff   <= 1'b0;
      mack_ff       <= 1'b0;
      have_data_ff  <= 1'b0;
      oe_b_ff       <= 1'b1;
      req_ff        <= 1'b0;
      sda_oe_b_out  <= 1'b1;
      sda_drive_out <= 1'b0;
    end else begin
      scl_q_ff      <= pins.scl;
      sda_q_ff      <= pins.sda;
      state_ff      <= nxt_state;
      bit_cnt_ff    <= nxt_bit_cnt;
      shift_ff      <= nxt_shift;
      addr_ff       <= nxt_addr;
      page_bit_ff   <= nxt_page_bit;
      mack_ff       <= nxt_mack;
      have_data_ff  <= nxt_have_data;
      oe_b_ff       <= nxt_oe_b;
      req_ff        <= req_ff ^ commit;
      sda_oe_b_out  <= nxt_oe_b;
      sda_drive_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Page buffer: up to sixteen bytes gathered, any count accepted.
  always_ff @(posedge link_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pmask_ff <= '0;
    end else if (start_ev || commit) begin
      pmask_ff <= '0;
    end else if (buf_we) begin
      pmask_ff[addr_ff[PAGE_ADDR_W-1:0]] <= 1'b1;
    end
  end

  // Later bytes at the same in-page index overwrite earlier ones.
  always_ff @(posedge link_clk_in) begin
    if (buf_we) begin
      pbuf[addr_ff[PAGE_ADDR_W-1:0]] <= shift_ff;
    end
  end

  // The whole page lands in one cycle, so the time does not grow with count.
  always_ff @(posedge link_clk_in) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (commit && pmask_ff[i]) begin
        mem[{addr_ff[MEM_ADDR_W-1:PAGE_ADDR_W], PAGE_ADDR_W'(i)}] <= pbuf[i];
      end
    end
  end

  // ==========================================================================
  // Internal write timer in the system domain, fed by a toggle handshake.
  eeprom_sync #(.WIDTH(1)) u_req_sync (
    .clk_in   (clock_in),
    .rst_b_in (rst_b_in),
    .d_in     (req_ff),
    .q_out    (req_s)
  );

  wire timer_go   = (req_s ^ ack_ff) & ~busy_ff;
  wire timer_done = busy_ff & (timer_ff == TIMER_ZERO);

  // One fixed duration for byte and page writes alike.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_ff        <= 1'b0;
      timer_ff       <= TIMER_ZERO;
      ack_ff         <= 1'b0;
      write_busy_out <= 1'b0;
    end else begin
      if (timer_go) begin
        busy_ff  <= 1'b1;
        timer_ff <= TIMER_W'(WRITE_CYCLES_P - 1);
      end else if (timer_done) begin
        busy_ff <= 1'b0;
        ack_ff  <= req_s;
      end else if (busy_ff) begin
        timer_ff <= timer_ff - TIMER_STEP;
      end
      write_busy_out <= busy_ff;
    end
  end

  // Helper length counter that only the checks read.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_len_ff <= TIMER_ZERO;
    end else begin
      busy_len_ff <= busy_ff ? busy_len_ff + TIMER_STEP : TIMER_ZERO;
    end
  end

  // ==========================================================================
  // Checks.
  chk_addr_ack_low: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    (state_ff == ST_SLAVE) && byte_end && addr_hit && !start_ev && !stop_ev
    |=> (state_ff == ST_ACK_ADDR) && !oe_b_ff ##1 !sda_oe_b_out)
    else $error("Matching slave address was not acknowledged low.");
  chk_type_mismatch: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    (state_ff == ST_SLAVE) && byte_end && !addr_hit && !start_ev && !stop_ev
    |=> (state_ff == ST_IDLE) && oe_b_ff)
    else $error("Foreign slave address was not ignored.");
  chk_write_byte_ack: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    ((state_ff == ST_WADDR) || (state_ff == ST_WDATA)) && byte_end && !start_ev && !stop_ev
    |=> (((state_ff == ST_ACK_WORD) || (state_ff == ST_ACK_DATA)) && !oe_b_ff) [*8])
    else $error("Received write byte was not acknowledged.");
  chk_nack_release: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    (state_ff == ST_RACK) && scl_fall && !mack_ff && !start_ev && !stop_ev
    |=> (state_ff == ST_WAITSTOP) && oe_b_ff)
    else $error("Data line not released after missing acknowledge.");
  chk_busy_no_ack: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    wr_busy && start_ev |=> (state_ff == ST_IDLE) && oe_b_ff)
    else $error("Command answered during internal write.");
  chk_commit_busy: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    commit |=> wr_busy [*3])
    else $error("Stop after data byte did not start an internal write.");
  chk_page_wrap: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    buf_we |=> (addr_ff[MEM_ADDR_W-1:PAGE_ADDR_W] == $past(addr_ff[MEM_ADDR_W-1:PAGE_ADDR_W]))
           && (addr_ff[PAGE_ADDR_W-1:0] == PAGE_ADDR_W'($past(addr_ff[PAGE_ADDR_W-1:0]) + PAGE_STEP)))
    else $error("Page address did not step inside its page.");
  chk_wp_inhibit: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    stop_ev && pins.wp |=> (req_ff == $past(req_ff)))
    else $error("Write started while write-protect was high.");
  chk_seq_inc: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    (state_ff == ST_RDATA) && byte_end && !start_ev && !stop_ev
    |=> addr_ff == MEM_ADDR_W'($past(addr_ff) + ADDR_STEP))
    else $error("Read address did not advance by one.");
  chk_write_time: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    $fell(busy_ff) |-> ($past(busy_len_ff) == TIMER_W'(WRITE_CYCLES_P - 1)))
    else $error("Internal write time differs from its set length.");

  cov_page_commit: cover property (@(posedge link_clk_in) disable iff (!rst_b_in)
    commit && (pmask_ff != '0));
  cov_seq_read: cover property (@(posedge link_clk_in) disable iff (!rst_b_in)
    (state_ff == ST_RACK) && scl_fall && mack_ff);
  cov_busy_start: cover property (@(posedge link_clk_in) disable iff (!rst_b_in)
    wr_busy && start_ev);

endmodule // eeprom_slave

`default_nettype wire

/* File: logic/eeprom_sync.sv */
// Two-flop synchroniser for a group of levels entering a clock domain.
`timescale 1ns/100ps
`default_nettype none

module eeprom_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);

  // ==========================================================================
  // Synchroniser stages.
  logic [WIDTH-1:0] meta_ff;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_ff <= '0;
      q_out   <= '0;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end

endmodule // eeprom_sync

`default_nettype wire

/* File: verification/i2c_master_model.sv */
// Behavioural two-wire bus master that drives the serial lines.
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
  input  wire logic clock_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_rel_out
);
  // ==========================================================================
  // Line control
  // Both lines idle high; sda_rel_out low pulls the wire low.
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  // A half step of 400 ns keeps each level long against the link sampler.
  task automatic half();
    repeat (4) @(posedge clock_in);
  endtask
  // Start or repeated start; data never moves on the same edge as scl.
  task automatic start();
    half();
    sda_rel_out <= 1'b1;
    half();
    scl_out <= 1'b1;
    half();
    sda_rel_out <= 1'b0;
    half();
    scl_out <= 1'b0;
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    half();
    sda_rel_out <= 1'b0;
    half();
    scl_out <= 1'b1;
    half();
    sda_rel_out <= 1'b1;
    half();
  endtask
  // One bit: data set while scl is low, wire sampled late in scl high.
  task automatic bit_io(input logic b, output logic r);
    half();
    sda_rel_out <= b;
    half();
    scl_out <= 1'b1;
    half();
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  // Sends a byte MSB first, then releases data for the acknowledge.
  task automatic put(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], nak);
    end
    bit_io(1'b1, nak);
  endtask
  // Reads a byte; a high acknowledge ends the read.
  task automatic get(input logic ak_b, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(ak_b, r);
  endtask
endmodule // i2c_master_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench: master model against the EEPROM slave engine.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import eeprom_pkg::*;
;
  localparam int WCYC = 400;
  logic       clock_in = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst_b    = 1'b0;
  logic       wp       = 1'b0;
  logic       pin2     = 1'b1;
  logic       pin1     = 1'b0;
  logic       k;
  logic [7:0] d;
  int         failures = 0;
  int         comparisons = 0;
  wire logic  scl;
  wire logic  rel;
  wire logic  oe_b;
  wire logic  drv;
  wire logic  busy;
  wire logic  sda_w;
  // Open-drain wire with pull-up: low if either party pulls it.
  assign sda_w = rel & (oe_b | drv);
  always #50 clock_in = ~clock_in;
  // Link clock at 30 ns, offset so it keeps no phase to the system clock.
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  eeprom_slave #(.WRITE_CYCLES_P(WCYC), .DEV_TYPE_P(DEV_TYPE_DEFAULT)) eeprom_slave_inst (
    .clock_in(clock_in), .rst_b_in(rst_b), .link_clk_in(link_clk), .scl_in(scl),
    .sda_in(sda_w), .device_select_pin_2_in(pin2), .device_select_pin_1_in(pin1),
    .write_protect_in(wp), .sda_drive_out(drv), .sda_oe_b_out(oe_b),
    .write_busy_out(busy));
  i2c_master_model mst (.clock_in(clock_in), .sda_in(sda_w), .scl_out(scl), .sda_rel_out(rel));
  // ==========================================================================
  // Checking helpers
  task automatic end_of_test();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask
  // Bounded wait for the busy flag; running out ends the run.
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl) begin
      @(posedge clock_in);
      n++;
      if (n > lim) begin
        failures++;
        $display("CHECK FAILED at %0t: busy wait ran out", $time);
        end_of_test();
      end
    end
  endtask
  function automatic logic [7:0] sa(input logic [1:0] sel, input logic pg, input logic rd);
    return {DEV_TYPE_DEFAULT, sel, pg, rd};
  endfunction
  // Start, write-mode slave byte and word byte, all acknowledged.
  task automatic addr(input logic [8:0] a);
    mst.start();
    mst.put(sa(2'b10, a[8], 1'b0), k);
    cmp1(k, 1'b0);
    mst.put(a[7:0], k);
    cmp1(k, 1'b0);
  endtask
  // Address phase, repeated start and read-mode slave byte.
  task automatic rstart(input logic [8:0] a);
    addr(a);
    mst.start();
    mst.put(sa(2'b10, 1'b0, 1'b1), k);
    cmp1(k, 1'b0);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    addr(a);
    mst.put(v, k);
    cmp1(k, 1'b0);
    mst.stop();
    wait_busy(1'b1, 40);
    wait_busy(1'b0, WCYC + 40);
  endtask
  // ==========================================================================
  // Scenarios
  // Three bytes from 0x10e wrap to 0x100; a command during busy is ignored.
  task automatic page_wrap();
    addr(9'h10e);
    mst.put(8'ha1, k);
    cmp1(k, 1'b0);
    mst.put(8'hb2, k);
    cmp1(k, 1'b0);
    mst.put(8'hc3, k);
    cmp1(k, 1'b0);
    mst.stop();
    wait_busy(1'b1, 40);
    mst.start();
    mst.put(sa(2'b10, 1'b0, 1'b0), k);
    cmp1(k, 1'b1);
    mst.stop();
    wait_busy(1'b0, WCYC + 40);
  endtask
  // Random read, then a current read, then the wrapped byte.
  task automatic reads();
    rstart(9'h10e);
    mst.get(1'b1, d);
    cmp8(d, 8'ha1);
    mst.stop();
    mst.start();
    mst.put(sa(2'b10, 1'b0, 1'b1), k);
    cmp1(k, 1'b0);
    mst.get(1'b1, d);
    cmp8(d, 8'hb2);
    mst.stop();
    rstart(9'h100);
    mst.get(1'b1, d);
    cmp8(d, 8'hc3);
    mst.stop();
  endtask
  // Wrong type code and wrong select bits get no acknowledge.
  task automatic mismatch();
    mst.start();
    mst.put(sa(2'b10, 1'b0, 1'b0) ^ 8'h80, k);
    cmp1(k, 1'b1);
    mst.stop();
    mst.start();
    mst.put(sa(2'b01, 1'b0, 1'b0), k);
    cmp1(k, 1'b1);
    mst.stop();
  endtask
  // Protected write has its address bytes acknowledged, starts no busy and leaves the array alone.
  task automatic protect();
    wp <= 1'b1;
    addr(9'h100);
    mst.put(8'h55, k);
    mst.stop();
    repeat (40) @(posedge clock_in);
    cmp1(busy, 1'b0);
    wp <= 1'b0;
    rstart(9'h100);
    mst.get(1'b1, d);
    cmp8(d, 8'hc3);
    mst.stop();
  endtask
  // Sequential read crosses from the top address to zero.
  task automatic seq_wrap();
    wr(9'h1ff, 8'h77);
    wr(9'h000, 8'h88);
    rstart(9'h1ff);
    mst.get(1'b0, d);
    cmp8(d, 8'h77);
    mst.get(1'b1, d);
    cmp8(d, 8'h88);
    mst.stop();
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clock_in);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock_in);
    cmp1(oe_b, 1'b1);
    cmp1(drv, 1'b0);
    page_wrap();
    reads();
    mismatch();
    protect();
    seq_wrap();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
